// ==== bench/sub_bus_chk.sv ====
// Checker for the subscriber bus between the initiator and target ends.
// Assumes its inputs are the plain signals of the interface joining them.
`timescale 1ns/1ns
`default_nettype none
module sub_bus_chk
  import sub_bus_pkg::*;
(
  input  wire logic       sys_clk_in,        // Bus clock
  input  wire logic       reset_n_in,        // Async reset, low active
  input  wire bus_addr_t  addr_bus,          // Resolved address lines
  input  wire bus_data_t  data_bus,          // Resolved data lines
  input  wire logic       addr_oe_n_init,    // Initiator address enable
  input  wire logic       data_oe_n_init,    // Initiator data enable
  input  wire logic [1:0] data_oe_n_tgt,     // Target lane enables
  input  wire logic       width_sel,         // 1 = word
  input  wire logic       write_n,           // Write strobe
  input  wire logic       read_n,            // Read strobe
  input  wire logic       operation_valid_n, // Operation valid
  input  wire logic       ack                // Transfer acknowledge
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  // Handshake: bounded answer, acknowledge drops the cycle after valid is removed
  property p_ack_delay; $fell(operation_valid_n) |-> !ack ##[1:4] ack; endproperty
  a_ack_delay: assert property (p_ack_delay) else $error("ack late");
  property p_ack_drop; ack && operation_valid_n |=> !ack; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  // Strobes, address and write data during an operation, address release after it
  property p_one_strobe; !operation_valid_n |-> write_n != read_n; endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobes");
  property p_addr_hold;
    !operation_valid_n && !$fell(operation_valid_n) |-> $stable(addr_bus) && $stable(width_sel);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
  property p_addr_float; $rose(operation_valid_n) |-> ##[0:2] addr_oe_n_init; endproperty
  a_addr_float: assert property (p_addr_float) else $error("addr held");
  property p_no_odd_word; !operation_valid_n |-> !(width_sel && addr_bus[0]); endproperty
  a_no_odd_word: assert property (p_no_odd_word) else $error("odd word");
  property p_wr_data; !operation_valid_n && !write_n |-> !data_oe_n_init; endproperty
  a_wr_data: assert property (p_wr_data) else $error("no wdata");
  // Target drives lanes only while answering a read, and only the chosen ones
  property p_tgt_quiet; data_oe_n_tgt != 2'b11 |-> ack && !read_n; endproperty
  a_tgt_quiet: assert property (p_tgt_quiet) else $error("stray drive");
  property p_read_lanes;
    ack && !read_n && !operation_valid_n |->
      data_oe_n_tgt == (width_sel ? (addr_bus[0] ? 2'b11 : 2'b00) : (addr_bus[0] ? 2'b01 : 2'b10));
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("lanes");
  property p_spare_lane;
    ack && !read_n && !operation_valid_n && !width_sel |->
      (addr_bus[0] ? data_bus[7:0] : data_bus[15:8]) == 8'hff;
  endproperty
  a_spare_lane: assert property (p_spare_lane) else $error("spare lane");

  c_write: cover property (ack && !write_n);
  c_word_read: cover property (ack && !read_n && width_sel);
  c_odd_read: cover property (ack && !read_n && !width_sel && addr_bus[0]);
endmodule : sub_bus_chk
`default_nettype wire

// ==== bench/testbench.sv ====
// Bench: initiator and target joined over one bus, plus a lone target
// fed by hand on a second bus to provoke the undefined width case.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sub_bus_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        req_in = 1'b0, write_in = 1'b0, word_in = 1'b0, space_in = 1'b1;
  bus_addr_t   addr_in = 16'h0000;
  bus_data_t   wdata_in = 16'h0000, rdata;
  logic [4:0]  local_id = 5'h00;
  logic        ready, done, bad, wr_seen, bad_seen, wr_seen_b, bad_seen_b;
  int          failures = 0, checks_done = 0, stores = 0, stores_seen = 0, bad_b = 0, stray = 0;
  logic [7:0]  mem [0:63];
  logic [31:0] seed = 32'h5846;
  sub_bus_if bus1 ();
  sub_bus_if bus2 ();

  always #2 sys_clk_in = ~sys_clk_in;
  sub_initiator sub_initiator_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .bus(bus1), .req_in(req_in), .write_in(write_in), .word_in(word_in), .space_in(space_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .ready_out(ready), .done_out(done),
    .bad_out(bad), .rdata_out(rdata));
  sub_target sub_target_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bus(bus1),
    .local_id_in(local_id), .wr_seen_out(wr_seen), .bad_seen_out(bad_seen));
  sub_target sub_target_inst_b (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bus(bus2),
    .local_id_in(local_id), .wr_seen_out(wr_seen_b), .bad_seen_out(bad_seen_b));
  sub_bus_chk sub_bus_chk_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .addr_bus(bus1.addr_bus), .data_bus(bus1.data_bus), .addr_oe_n_init(bus1.addr_oe_n_init),
    .data_oe_n_init(bus1.data_oe_n_init), .data_oe_n_tgt(bus1.data_oe_n_tgt),
    .width_sel(bus1.width_sel), .write_n(bus1.write_n), .read_n(bus1.read_n),
    .operation_valid_n(bus1.operation_valid_n), .ack(bus1.ack));

  // Tally target pulses; the paired target must never see an odd word
  always @(posedge sys_clk_in) begin
    stores_seen <= stores_seen + int'(wr_seen === 1'b1);
    bad_b <= bad_b + int'(bad_seen_b === 1'b1);
    stray <= stray + int'(bad_seen === 1'b1) + int'(wr_seen_b === 1'b1);
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input bus_data_t got, input bus_data_t exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One user request; bounded waits so a missing answer cannot hang us
  task automatic xfer(input logic wr, input logic wd, input bus_addr_t a, input bus_data_t d,
                      input logic exp_ok, output bus_data_t rd);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    {write_in, word_in, addr_in, wdata_in, req_in} = {wr, wd, a, d, 1'b1};
    @(negedge sys_clk_in);
    req_in = 1'b0;
    n = 0;
    while (done !== 1'b1 && bad !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk({15'h0000, done === 1'b1}, {15'h0000, exp_ok}, "done");
    chk({15'h0000, bad === 1'b1}, {15'h0000, !exp_ok}, "refused");
    rd = rdata;
  endtask : xfer

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin : watchdog
    #20000;
    failures++;
    complete_run();
  end

  initial begin : main
    logic [31:0] r;
    bus_data_t   rd, msk;
    int          o, n;
    logic        wd;
    {bus2.addr_oe_n_init, bus2.data_oe_n_init, bus2.width_sel, bus2.space_sel_n} = 4'hf;
    {bus2.write_n, bus2.read_n, bus2.operation_valid_n} = 3'h7;
    {bus2.addr_from_init, bus2.data_from_init} = 32'h0000_0000;
    r = xs();
    local_id = (r[12:8] == 5'h00) ? 5'h01 : r[12:8]; // Identity 0 is the supervisor's
    repeat (5) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    // Fill the first 64 bytes of the window with words so every later read has a known answer
    for (o = 0; o < 64; o += 2) begin
      r = xs();
      xfer(1'b1, 1'b1, {local_id, 5'h00, 6'(o)}, r[15:0], 1'b1, rd);
      {mem[o + 1], mem[o]} = r[15:0];
      stores++;
    end
    // Random mix of even bytes, odd bytes and words, both directions
    for (int k = 0; k < 60; k++) begin
      r = xs();
      o = int'(r[5:0]);
      wd = r[6] && !r[0];
      xfer(r[7], wd, {local_id, 5'h00, r[5:0]}, r[31:16], 1'b1, rd);
      msk = wd ? 16'hffff : (r[0] ? 16'hff00 : 16'h00ff);
      if (r[7]) begin
        stores++;
        if (wd || !r[0]) mem[o & 62] = r[23:16];
        if (wd || r[0]) mem[o | 1] = r[31:24];
      end else begin
        chk(rd & msk, {mem[o | 1], mem[o & 62]} & msk, "read data");
      end
    end
    // Word at an odd address is refused without any bus cycle
    xfer(1'b1, 1'b1, {local_id, 11'h005}, 16'h1234, 1'b0, rd);
    // Lone target: undefined combination, read then write, must not drive or store
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk_in);
      {bus2.addr_from_init, bus2.data_from_init} = {local_id, 11'h011, 16'h5aa5};
      {bus2.addr_oe_n_init, bus2.width_sel, bus2.data_oe_n_init} = {2'b01, ~k[0]};
      @(negedge sys_clk_in);
      {bus2.operation_valid_n, bus2.write_n, bus2.read_n} = {1'b0, ~k[0], k[0]};
      n = 0;
      while (bus2.ack !== 1'b1 && n < 20) begin
        @(negedge sys_clk_in);
        n++;
      end
      chk({15'h0000, bus2.ack}, 16'h0001, "odd word ack");
      chk(bus2.data_bus, k[0] ? 16'h5aa5 : 16'hffff, "odd word lanes");
      {bus2.operation_valid_n, bus2.write_n, bus2.read_n, bus2.data_oe_n_init} = 4'hf;
      bus2.addr_oe_n_init = 1'b1;
      repeat (4) @(negedge sys_clk_in);
    end
    // Lone target: another identity, then the passive area, must draw no answer
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk_in);
      bus2.addr_from_init = {(k == 0) ? ~local_id : local_id, 11'h010};
      bus2.space_sel_n = (k != 0) ? 1'b0 : 1'b1;
      {bus2.addr_oe_n_init, bus2.width_sel, bus2.data_oe_n_init} = 3'b000;
      @(negedge sys_clk_in);
      {bus2.operation_valid_n, bus2.write_n} = 2'b00;
      n = 0;
      repeat (8) begin
        @(negedge sys_clk_in);
        if (bus2.ack !== 1'b0) n++;
      end
      chk(16'(n), 16'h0000, "foreign ack");
      {bus2.operation_valid_n, bus2.write_n, bus2.data_oe_n_init} = 3'h7;
      {bus2.addr_oe_n_init, bus2.space_sel_n} = 2'h3;
      repeat (4) @(negedge sys_clk_in);
    end
    chk(16'(bad_b), 16'h0002, "odd word seen");
    chk(16'(stray), 16'h0000, "stray pulses");
    chk(16'(stores_seen), 16'(stores), "stores");
    complete_run();
  end
endmodule : testbench
`default_nettype wire

// ==== rtl/lane_decode.sv ====
// Byte lane decoder shared by both ends.
// Assumes address bit 0 and width select are already stable for the transfer.
`timescale 1ns/1ns
`default_nettype none
module lane_decode
  import sub_bus_pkg::*;
(
  input  wire logic      addr_bit0_in,   // Lowest address bit
  input  wire logic      width_sel_in,   // 1 = word transfer
  output lane_sel_t      lane_sel_out,   // Decoded transfer kind
  output logic [1:0]     lane_en_out     // Active byte lanes, bit 1 = high lane
);
  // Address bit 0 is the byte address lowest weight; bytes are the finest unit
  always_comb begin
    case ({width_sel_in, addr_bit0_in})
      2'h0: begin
        lane_sel_out = width_byte_even;
        lane_en_out  = 2'h1;
      end
      2'h1: begin
        lane_sel_out = width_byte_odd;
        lane_en_out  = 2'h2;
      end
      2'h2: begin
        lane_sel_out = width_word;
        lane_en_out  = 2'h3;
      end
      default: begin
        lane_sel_out = width_bad;
        lane_en_out  = 2'h0;
      end
    endcase
  end
endmodule : lane_decode
`default_nettype wire

// ==== rtl/sub_bus_consts.svh ====
// Constants for the subscriber data transfer port of the 16-bit backplane bus.
// Assumes inclusion from the package and both end modules; definitions only.
`ifndef SUB_BUS_CONSTS_SVH
`define SUB_BUS_CONSTS_SVH

`define ADDR_W        16
`define DATA_W        16
`define ID_HI         15
`define ID_LO         11
`define ID_W          5
`define WIN_W         11
`define WIN_WORDS     1024
`define LANE_LO_MSB   7
`define LANE_HI_LSB   8
`define ACK_DELAY     2
`define ACK_CNT_W     2
`define ADDR_IDLE     16'hffff
`define DATA_IDLE     16'hffff
`define LOCAL_ID_RST  5'h01

`endif

// ==== rtl/sub_bus_if.sv ====
// Bus wires between the initiator and the target subscriber.
// Each two-way line is resolved here from its drivers' low-active enables;
// an undriven line reads as one, as the backplane pull-ups make it.
`timescale 1ns/1ns
`default_nettype none
`include "sub_bus_consts.svh"
interface sub_bus_if;
  import sub_bus_pkg::*;
  bus_addr_t addr_from_init;       // Initiator address drive
  logic      addr_oe_n_init;       // Low while initiator drives address
  bus_data_t data_from_init;       // Initiator data drive
  logic      data_oe_n_init;       // Low while initiator drives data
  bus_data_t data_from_tgt;        // Target data drive
  logic [1:0] data_oe_n_tgt;       // Per byte lane, low while target drives
  logic      width_sel;            // transfer_width_select, 1 = word
  logic      space_sel_n;          // 1 = active transfer area, 0 = passive area
  logic      write_n;              // Write strobe, low active
  logic      read_n;               // Read strobe, low active
  logic      operation_valid_n;    // Operation valid, low active
  logic      ack;                  // Transfer acknowledge, high active
  bus_addr_t addr_bus;             // Resolved address lines
  bus_data_t data_bus;             // Resolved data lines

  assign addr_bus = addr_oe_n_init ? `ADDR_IDLE : addr_from_init;
  assign data_bus[`LANE_LO_MSB:0] = !data_oe_n_tgt[0] ? data_from_tgt[`LANE_LO_MSB:0] :
      (!data_oe_n_init ? data_from_init[`LANE_LO_MSB:0] : 8'(`DATA_IDLE));
  assign data_bus[`DATA_W-1:`LANE_HI_LSB] = !data_oe_n_tgt[1] ?
      data_from_tgt[`DATA_W-1:`LANE_HI_LSB] :
      (!data_oe_n_init ? data_from_init[`DATA_W-1:`LANE_HI_LSB] :
       8'(`DATA_IDLE >> `LANE_HI_LSB));

  modport initiator (
    output addr_from_init, addr_oe_n_init, data_from_init, data_oe_n_init,
    output width_sel, space_sel_n, write_n, read_n, operation_valid_n,
    input  data_bus, ack
  );
  modport target (
    output data_from_tgt, data_oe_n_tgt, ack,
    input  addr_bus, data_bus, width_sel, space_sel_n, write_n, read_n,
    input  operation_valid_n
  );
endinterface : sub_bus_if
`default_nettype wire

// ==== rtl/sub_bus_pkg.sv ====
// Types shared by both ends of the subscriber port.
// Assumes the constants header is found on the include path.
`include "sub_bus_consts.svh"
package sub_bus_pkg;
  typedef logic [`ADDR_W-1:0] bus_addr_t;
  typedef logic [`DATA_W-1:0] bus_data_t;
  typedef enum logic [1:0] {
    width_byte_even,
    width_byte_odd,
    width_word,
    width_bad
  } lane_sel_t;
  typedef enum logic {
    op_read,
    op_write
  } op_kind_t;
endpackage : sub_bus_pkg

// ==== rtl/sub_initiator.sv ====
// Active subscriber end: runs one read or write per user request.
// Assumes the target acknowledges; there is no timeout on a missing answer.
`timescale 1ns/1ns
`default_nettype none
`include "sub_bus_consts.svh"
module sub_initiator
  import sub_bus_pkg::*;
(
  input  wire logic      sys_clk_in,   // 250 MHz clock
  input  wire logic      reset_n_in,   // Async reset, low active
  sub_bus_if.initiator   bus,          // Backplane side
  input  wire logic      req_in,       // Start request, level
  input  wire logic      write_in,     // 1 = write, 0 = read
  input  wire logic      word_in,      // 1 = word, 0 = byte
  input  wire logic      space_in,     // 1 = active transfer area
  input  wire bus_addr_t addr_in,      // Byte address
  input  wire bus_data_t wdata_in,     // Write data, lane aligned
  output logic           ready_out,    // High while a request can be taken
  output logic           done_out,     // Pulse when transfer ends
  output logic           bad_out,      // Pulse when request refused
  output bus_data_t      rdata_out     // Read data, lane aligned
);
  typedef enum logic [1:0] {idle, drive, wait_ack, release_bus} ini_state_t;
  ini_state_t state_q;
  op_kind_t   kind_q;
  logic       word_q;
  logic       space_q;
  bus_addr_t  addr_q;
  bus_data_t  wdata_q;
  lane_sel_t  lane_sel;

  lane_decode u_lane (
    .addr_bit0_in (addr_in[0]),
    .width_sel_in (word_in),
    .lane_sel_out (lane_sel),
    .lane_en_out  ()
  );

  assign ready_out = (state_q == idle);

  // Sequence: drive address, then valid, wait ack, release
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= idle;
      kind_q  <= op_read;
      word_q  <= 1'b0;
      space_q <= 1'b1;
      addr_q  <= `ADDR_IDLE;
      wdata_q <= `DATA_IDLE;
    end else begin
      case (state_q)
        idle: if (req_in && lane_sel != width_bad) begin
          state_q <= drive;
          kind_q  <= write_in ? op_write : op_read;
          word_q  <= word_in;
          space_q <= space_in;
          addr_q  <= addr_in;
          wdata_q <= wdata_in;
        end
        drive:       state_q <= wait_ack;
        wait_ack:    if (bus.ack) state_q <= release_bus;
        release_bus: if (!bus.ack) state_q <= idle;
        default:     state_q <= idle;
      endcase
    end
  end

  // Bus drive; address floats outside a transfer
  assign bus.addr_from_init    = addr_q;
  assign bus.addr_oe_n_init    = (state_q == idle);
  assign bus.data_from_init    = wdata_q;
  assign bus.data_oe_n_init    = !((state_q == drive || state_q == wait_ack) &&
                                   kind_q == op_write);
  assign bus.width_sel         = word_q;
  assign bus.space_sel_n       = space_q;
  assign bus.write_n           = !(state_q == wait_ack && kind_q == op_write);
  assign bus.read_n            = !(state_q == wait_ack && kind_q == op_read);
  assign bus.operation_valid_n = (state_q != wait_ack);

  // Read capture on the acknowledge edge; result stays until the next read
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rdata_out <= '0;
    else if (state_q == wait_ack && bus.ack && kind_q == op_read) rdata_out <= bus.data_bus;
  end

  // Completion and refusal pulses
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
      bad_out  <= 1'b0;
    end else begin
      done_out <= (state_q == wait_ack) && bus.ack;
      bad_out  <= (state_q == idle) && req_in && (lane_sel == width_bad);
    end
  end
endmodule : sub_initiator
`default_nettype wire

// ==== rtl/sub_target.sv ====
// Passive-responding subscriber end with a 2 kbyte transfer memory.
// Assumes the initiator holds address, width and write data stable
// from operation valid until it sees the acknowledge.
`timescale 1ns/1ns
`default_nettype none
`include "sub_bus_consts.svh"
module sub_target
  import sub_bus_pkg::*;
(
  input  wire logic            sys_clk_in,     // 250 MHz clock
  input  wire logic            reset_n_in,     // Async reset, low active
  sub_bus_if.target            bus,            // Backplane side
  input  wire logic [`ID_W-1:0] local_id_in,   // Local address setting
  output logic                 wr_seen_out,    // Pulse per stored write
  output logic                 bad_seen_out    // Pulse per undefined access
);
  typedef enum logic [1:0] {idle, wait_ack, hold_ack} tgt_state_t;
  tgt_state_t              state_q;
  logic [`ACK_CNT_W-1:0]   cnt_q;
  logic [`DATA_W-1:0]      mem_q [`WIN_WORDS];
  logic [`DATA_W-1:0]      rd_q;
  logic [1:0]              oe_n_q;
  logic [`ID_W-1:0]        id_q;
  logic                    sel;
  logic                    req;
  lane_sel_t               lane_sel;
  logic [1:0]              lane_en;
  logic [`WIN_W-2:0]       word_idx;

  lane_decode u_lane (
    .addr_bit0_in (bus.addr_bus[0]),
    .width_sel_in (bus.width_sel),
    .lane_sel_out (lane_sel),
    .lane_en_out  (lane_en)
  );

  // Setting latched each clock so a changing switch never glitches the compare
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) id_q <= `LOCAL_ID_RST;
    else id_q <= local_id_in;
  end

  // Select only in the active area when the identity bits match the setting
  assign sel = bus.space_sel_n &&
               (bus.addr_bus[`ID_HI:`ID_LO] == id_q);
  // Exactly one strobe; both low is not an operation this end answers
  assign req = !bus.operation_valid_n && sel &&
               (bus.write_n ^ bus.read_n);
  assign word_idx = bus.addr_bus[`WIN_W-1:1];

  // Handshake: respond only to a valid operation, never start one
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= idle;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        idle: if (req) begin
          state_q <= wait_ack;
          cnt_q   <= '0;
        end
        wait_ack: begin
          if (bus.operation_valid_n) state_q <= idle;
          else if (cnt_q == `ACK_CNT_W'(`ACK_DELAY - 1)) state_q <= hold_ack;
          else cnt_q <= cnt_q + `ACK_CNT_W'(1);
        end
        hold_ack: if (bus.operation_valid_n) state_q <= idle;    // Ack holds until release
        default: state_q <= idle;
      endcase
    end
  end
  assign bus.ack = (state_q == hold_ack);

  // Store only the selected lanes, once, as the acknowledge begins
  always_ff @(posedge sys_clk_in) begin
    if (state_q == wait_ack && cnt_q == `ACK_CNT_W'(`ACK_DELAY - 1) &&
        !bus.write_n && !bus.operation_valid_n && lane_sel != width_bad) begin
      if (lane_en[0]) mem_q[word_idx][`LANE_LO_MSB:0] <= bus.data_bus[`LANE_LO_MSB:0];
      if (lane_en[1])
        mem_q[word_idx][`DATA_W-1:`LANE_HI_LSB] <= bus.data_bus[`DATA_W-1:`LANE_HI_LSB];
    end
  end

  // Read data and lane enables; an unused lane stays floating
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_q   <= '0;
      oe_n_q <= 2'h3;
    end else if (state_q == wait_ack && !bus.read_n && !bus.operation_valid_n &&
                 cnt_q == `ACK_CNT_W'(`ACK_DELAY - 1)) begin
      rd_q   <= mem_q[word_idx];
      oe_n_q <= ~lane_en;
    end else if (state_q != hold_ack || bus.operation_valid_n) begin
      oe_n_q <= 2'h3;
    end
  end
  assign bus.data_from_tgt = rd_q;
  // Lanes float as soon as valid rises, so no drive outlives the read strobe
  assign bus.data_oe_n_tgt = oe_n_q | {2{bus.operation_valid_n}};

  // Status pulses for the local side
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_seen_out  <= 1'b0;
      bad_seen_out <= 1'b0;
    end else begin
      wr_seen_out  <= (state_q == wait_ack) && (cnt_q == `ACK_CNT_W'(`ACK_DELAY - 1)) &&
                      !bus.write_n && !bus.operation_valid_n && (lane_sel != width_bad);
      bad_seen_out <= (state_q == idle) && req && (lane_sel == width_bad);
    end
  end
endmodule : sub_target
`default_nettype wire
